// ---- verilog/gpio_port.sv ----
/*
  Configurable I/O port logic for ports 0, 1 and 3 with APB register access.
  Assumes pclk is also the internal RC oscillator clock, and that the pad
  resolves the pull and drive controls into a pin level fed back on pin_in.
  Fixed-function pin positions come from package constants.
*/
// The APB slave port and the register addresses are this design's own decisions.
// Functional notes
// - Two select bits per pin: 00 quasi, low-only input only, both open drain.
// - After reset every configurable pin is quasi-bidirectional.
// - Both bus pins ignore mode bits and stay open drain.
// - One select bit per port picks Schmitt or TTL inputs.
// - Clock output pin drives RC clock divided by four when enabled with the RC source bit set.
// - Quasi mode: very weak pull-up on whenever latch holds one.
// - Quasi mode: weak pull-up on only while sensed pin is high.
// - Quasi mode: latch rise turns strong pull-up on for two clocks.
// - Quasi mode: latch zero drives low strongly, one weakly apart from the strong pulse on a rise.
// - Read-modify-write reads the latch, modifies, writes latch back.
// - Latch read covers logic ops, jump-clear, complement, inc, dec, loops, bit moves.
// - Single-bit writes rewrite the whole latch byte, one bit altered.
// - Open drain: no pull-ups, pull-down only while latch is zero.
// - Push-pull: strong high while latch is one, low while zero.
`timescale 1ns/1ps
module gpio_port
  import gpio_pkg::*;
#(
  parameter int STRONG_CYCLES = STRONG_PULLUP_CYCLES
) (
  // APB clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Pin levels and drive, index port*8 + bit
  input  wire logic [NUM_PINS-1:0] pin_in,
  output logic      [NUM_PINS-1:0] pin_out,
  output logic      [NUM_PINS-1:0] pin_oe,
  // Pad driver controls
  output logic      [NUM_PINS-1:0] pull_down,
  output logic      [NUM_PINS-1:0] strong_pull_up,
  output logic      [NUM_PINS-1:0] weak_pull_up,
  output logic      [NUM_PINS-1:0] very_weak_pull_up,
  // Input buffer type, one bit per port
  output logic      [NUM_PORTS-1:0] schmitt_select
);

  // Wide enough to hold the pulse length
  localparam int STRONG_W = $clog2(STRONG_CYCLES + 1);
  localparam int DIV_W    = (CLKOUT_HALF > 1) ? $clog2(CLKOUT_HALF) : 1;
  localparam logic [STRONG_W-1:0] STRONG_LOAD = STRONG_W'(STRONG_CYCLES);
  localparam logic [DIV_W-1:0]    DIV_LAST    = DIV_W'(CLKOUT_HALF - 1);

  initial begin
    if (STRONG_CYCLES < 1) $error("STRONG_CYCLES must be at least one");
    if (CLKOUT_HALF < 1) $error("clock output divider too small");
    if (PORT_W != 8) $error("registers carry one byte per port");
    if (NUM_PORTS > 3) $error("command port field serves three ports");
  end

  typedef struct packed {
    // Software-visible registers
    logic [NUM_PORTS-1:0][PORT_W-1:0]   port_latch;
    logic [NUM_PORTS-1:0][PORT_W-1:0]   pin_mode_select_low;
    logic [NUM_PORTS-1:0][PORT_W-1:0]   pin_mode_select_high;
    logic [NUM_PORTS-1:0]               schmitt;
    logic                               clkout_en;
    logic                               rc_source;
    logic [8:0]                         rmw_result;

    // Pulse and divider timers
    logic [NUM_PINS-1:0][STRONG_W-1:0]  strong_cnt;
    logic [DIV_W-1:0]                   div_cnt;
    logic                               div_clk;

    // Bus response
    logic                               pready;
    logic                               pslverr;
    logic [31:0]                        prdata;

    // Pad drive
    logic [NUM_PINS-1:0]                pin_out;
    logic [NUM_PINS-1:0]                pin_oe;
    logic [NUM_PINS-1:0]                pull_down;
    logic [NUM_PINS-1:0]                strong_pull_up;
    logic [NUM_PINS-1:0]                weak_pull_up;
    logic [NUM_PINS-1:0]                very_weak_pull_up;
  } port_state_t;

  port_state_t         cur;
  port_state_t         next_cur;
  // Pin levels, four flops behind the pad
  logic [NUM_PINS-1:0] pin_level;

  pin_sync #(
    .WIDTH    (NUM_PINS)
  ) u_pin_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (pin_in),
    .level    (pin_level)
  );

  // Anything else answers with an error
  function automatic logic addr_mapped(input logic [7:0] addr);
    case (addr)
      REG_PORT0, REG_PORT1, REG_PORT3,
      REG_MODE_LO0, REG_MODE_LO1, REG_MODE_LO3,
      REG_MODE_HI0, REG_MODE_HI1, REG_MODE_HI3,
      REG_CONFIG, REG_RMW_CMD, REG_RMW_RESULT: addr_mapped = 1'b1;
      default:                                 addr_mapped = 1'b0;
    endcase
  endfunction

  // Operates on the latch byte, never on the pin levels
  function automatic logic [8:0] rmw_exec(input logic [3:0] op,
                                          input logic [7:0] val,
                                          input logic [7:0] arg,
                                          input logic [2:0] idx,
                                          input logic       carry);
    logic [7:0] res;
    logic       flag;
    res  = val;
    flag = 1'b0;
    case (op)
      OP_AND:  res = val & arg;
      OP_OR:   res = val | arg;
      OP_XOR:  res = val ^ arg;
      // Flag carries the old bit
      OP_JBC: begin
        flag     = val[idx];
        res[idx] = 1'b0;
      end
      OP_CPL:  res[idx] = ~val[idx];
      OP_INC:  res = val + 8'h01;
      OP_DEC:  res = val - 8'h01;
      // Flag set while the count is not zero
      OP_DJNZ: begin
        res  = val - 8'h01;
        flag = (res != 8'h00);
      end
      OP_MOVC: res[idx] = carry;
      OP_CLR:  res[idx] = 1'b0;
      OP_SET:  res[idx] = 1'b1;
      // Unknown op leaves the byte alone
      default: res = val;
    endcase
    return {flag, res};
  endfunction

  always_comb begin
    logic [31:0]         rd;
    logic [8:0]          rmw;
    logic [1:0]          rmw_port;
    logic [1:0]          mode;
    logic                lat;
    logic                rise;
    logic                quasi;
    logic                clk_pin;
    int                  i;

    rd       = 32'h0000_0000;
    rmw      = 9'h000;
    rmw_port = 2'h0;
    mode     = MODE_QUASI;
    lat      = 1'b0;
    rise     = 1'b0;
    quasi    = 1'b0;
    clk_pin  = 1'b0;
    i        = 0;
    next_cur = cur;

    // APB: data captured on the first access edge, completion on the next
    next_cur.pready = 1'b0;
    if (psel && penable && !cur.pready) begin
      case (paddr)
        // Port reads see the pins, not the latch
        REG_PORT0:      rd = {24'h000000, pin_level[0 +: PORT_W]};
        REG_PORT1:      rd = {24'h000000, pin_level[PORT_W +: PORT_W]};
        REG_PORT3:      rd = {24'h000000, pin_level[2*PORT_W +: PORT_W]};
        REG_MODE_LO0:   rd = {24'h000000, cur.pin_mode_select_low[0]};
        REG_MODE_LO1:   rd = {24'h000000, cur.pin_mode_select_low[1]};
        REG_MODE_LO3:   rd = {24'h000000, cur.pin_mode_select_low[2]};
        REG_MODE_HI0:   rd = {24'h000000, cur.pin_mode_select_high[0]};
        REG_MODE_HI1:   rd = {24'h000000, cur.pin_mode_select_high[1]};
        REG_MODE_HI3:   rd = {24'h000000, cur.pin_mode_select_high[2]};
        REG_CONFIG: begin
          rd[CFG_SCHMITT0]  = cur.schmitt[0];
          rd[CFG_SCHMITT1]  = cur.schmitt[1];
          rd[CFG_SCHMITT3]  = cur.schmitt[2];
          rd[CFG_CLKOUT_EN] = cur.clkout_en;
          rd[CFG_RC_SOURCE] = cur.rc_source;
        end
        REG_RMW_RESULT: rd = {23'h000000, cur.rmw_result};
        default:        rd = 32'h0000_0000;
      endcase
      next_cur.pready  = 1'b1;
      next_cur.prdata  = rd;
      // Unmapped: error flag, data zero
      next_cur.pslverr = !addr_mapped(paddr);
    end

    // Writes take effect only at the completing edge
    // Read-only and unmapped offsets are dropped
    if (psel && penable && cur.pready && pwrite) begin
      case (paddr)
        REG_PORT0:    next_cur.port_latch[0] = pwdata[7:0];
        REG_PORT1:    next_cur.port_latch[1] = pwdata[7:0];
        REG_PORT3:    next_cur.port_latch[2] = pwdata[7:0];
        REG_MODE_LO0: next_cur.pin_mode_select_low[0] = pwdata[7:0];
        REG_MODE_LO1: next_cur.pin_mode_select_low[1] = pwdata[7:0];
        REG_MODE_LO3: next_cur.pin_mode_select_low[2] = pwdata[7:0];
        REG_MODE_HI0: next_cur.pin_mode_select_high[0] = pwdata[7:0];
        REG_MODE_HI1: next_cur.pin_mode_select_high[1] = pwdata[7:0];
        REG_MODE_HI3: next_cur.pin_mode_select_high[2] = pwdata[7:0];
        REG_CONFIG: begin
          next_cur.schmitt[0] = pwdata[CFG_SCHMITT0];
          next_cur.schmitt[1] = pwdata[CFG_SCHMITT1];
          next_cur.schmitt[2] = pwdata[CFG_SCHMITT3];
          next_cur.clkout_en  = pwdata[CFG_CLKOUT_EN];
          next_cur.rc_source  = pwdata[CFG_RC_SOURCE];
        end
        REG_RMW_CMD: begin
          rmw_port = pwdata[RMW_PORT_LSB +: 2];
          // Port select 3 names no port and is dropped
          if (rmw_port < 2'(NUM_PORTS)) begin
            rmw = rmw_exec(pwdata[RMW_OP_LSB +: 4], cur.port_latch[rmw_port],
                           pwdata[RMW_ARG_LSB +: 8], pwdata[RMW_BIT_LSB +: 3],
                           pwdata[RMW_CARRY_BIT]);
            next_cur.port_latch[rmw_port] = rmw[7:0];
            // Result keeps the flag for software to poll
            next_cur.rmw_result           = rmw;
          end
        end
        default: ;
      endcase
    end

    // Clock output divider runs on pclk, the RC clock here
    // Free-running, so enabling it needs no restart
    if (cur.div_cnt == DIV_LAST) begin
      next_cur.div_cnt = '0;
      next_cur.div_clk = ~cur.div_clk;
    end else begin
      next_cur.div_cnt = cur.div_cnt + DIV_W'(1);
    end
    clk_pin = cur.clkout_en && cur.rc_source;

    // Drive decoded from next latch so pads follow writes at once
    for (int p = 0; p < NUM_PORTS; p++) begin
      for (int b = 0; b < PORT_W; b++) begin
        i    = p * PORT_W + b;
        lat  = next_cur.port_latch[p][b];
        rise = lat && !cur.port_latch[p][b];
        mode = {next_cur.pin_mode_select_high[p][b], next_cur.pin_mode_select_low[p][b]};
        // Bus pins stay open drain whatever is written
        if (p == BUS_PORT && (b == BUS_CLOCK_BIT || b == BUS_DATA_BIT)) begin
          mode = MODE_OPEN_DRAIN;
        end
        quasi = (mode == MODE_QUASI);

        // A latch drop ends the pulse so it never fights the pull-down
        if (!quasi) begin
          next_cur.strong_cnt[i] = '0;
        end else if (rise) begin
          next_cur.strong_cnt[i] = STRONG_LOAD;
        end else if (!lat) begin
          next_cur.strong_cnt[i] = '0;
        end else if (cur.strong_cnt[i] != '0) begin
          next_cur.strong_cnt[i] = cur.strong_cnt[i] - STRONG_W'(1);
        end

        next_cur.pull_down[i]         = 1'b0;
        next_cur.strong_pull_up[i]    = 1'b0;
        next_cur.weak_pull_up[i]      = 1'b0;
        next_cur.very_weak_pull_up[i] = 1'b0;
        case (mode)
          MODE_QUASI: begin
            next_cur.pull_down[i]         = !lat;
            next_cur.very_weak_pull_up[i] = lat;
            // An outside low turns the weak pull off
            next_cur.weak_pull_up[i]      = pin_level[i];
            next_cur.strong_pull_up[i]    = (next_cur.strong_cnt[i] != '0);
          end
          MODE_PUSH_PULL: begin
            next_cur.pull_down[i]      = !lat;
            next_cur.strong_pull_up[i] = lat;
          end
          MODE_OPEN_DRAIN: begin
            // No pull-up; needs an outside resistor
            next_cur.pull_down[i] = !lat;
          end
          // High impedance: every driver off
          MODE_INPUT_ONLY: ;
          default: ;
        endcase

        // Clock output overrides mode and latch
        if (p == CLKOUT_PORT && b == CLKOUT_BIT && clk_pin) begin
          next_cur.pull_down[i]         = !next_cur.div_clk;
          next_cur.strong_pull_up[i]    = next_cur.div_clk;
          next_cur.weak_pull_up[i]      = 1'b0;
          next_cur.very_weak_pull_up[i] = 1'b0;
        end

        // Only strong drive counts as driving; weak pulls go out separately
        next_cur.pin_oe[i]  = next_cur.pull_down[i] || next_cur.strong_pull_up[i];
        next_cur.pin_out[i] = next_cur.strong_pull_up[i];
      end
    end
  end

  // Drive stays off while reset is held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur                      <= '0;
      cur.port_latch           <= {PORT3_RESET, PORT1_RESET, PORT0_RESET};
      cur.pin_mode_select_low  <= {MODE_RESET, MODE_RESET, MODE_RESET};
      cur.pin_mode_select_high <= {MODE_RESET, MODE_RESET, MODE_RESET};
    end else begin
      cur <= next_cur;
    end
  end

  // Every output comes straight from a register
  assign prdata            = cur.prdata;
  assign pready            = cur.pready;
  assign pslverr           = cur.pslverr;
  assign pin_out           = cur.pin_out;
  assign pin_oe            = cur.pin_oe;
  assign pull_down         = cur.pull_down;
  assign strong_pull_up    = cur.strong_pull_up;
  assign weak_pull_up      = cur.weak_pull_up;
  assign very_weak_pull_up = cur.very_weak_pull_up;
  assign schmitt_select    = cur.schmitt;

endmodule // gpio_port

// ---- verilog/gpio_pkg.sv ----
/*
  Constants shared by the port block: register offsets, field positions,
  reset values, output mode encodings and timing counts.
  Assumes a 32-bit APB slave with an 8-bit byte address.
*/
package gpio_pkg;

  // Port geometry: index 0, 1 and 2 stand for ports 0, 1 and 3
  localparam int PORT_W    = 8;
  localparam int NUM_PORTS = 3;
  localparam int NUM_PINS  = PORT_W * NUM_PORTS;

  // Register byte offsets
  localparam logic [7:0] REG_PORT0      = 8'h00;
  localparam logic [7:0] REG_PORT1      = 8'h04;
  localparam logic [7:0] REG_PORT3      = 8'h08;
  localparam logic [7:0] REG_MODE_LO0   = 8'h0c;
  localparam logic [7:0] REG_MODE_LO1   = 8'h10;
  localparam logic [7:0] REG_MODE_LO3   = 8'h14;
  localparam logic [7:0] REG_MODE_HI0   = 8'h18;
  localparam logic [7:0] REG_MODE_HI1   = 8'h1c;
  localparam logic [7:0] REG_MODE_HI3   = 8'h20;
  localparam logic [7:0] REG_CONFIG     = 8'h24;
  localparam logic [7:0] REG_RMW_CMD    = 8'h28;
  localparam logic [7:0] REG_RMW_RESULT = 8'h2c;

  // Reset values
  localparam logic [7:0] PORT0_RESET = 8'hff;
  localparam logic [7:0] PORT1_RESET = 8'hff;
  localparam logic [7:0] PORT3_RESET = 8'h03;
  localparam logic [7:0] MODE_RESET  = 8'h00;

  // Output modes as {pin_mode_select_high, pin_mode_select_low}
  localparam logic [1:0] MODE_QUASI      = 2'h0;
  localparam logic [1:0] MODE_INPUT_ONLY = 2'h1;
  localparam logic [1:0] MODE_PUSH_PULL  = 2'h2;
  localparam logic [1:0] MODE_OPEN_DRAIN = 2'h3;

  // Fixed-function pins (port index, bit)
  localparam int BUS_PORT       = 1;
  localparam int BUS_CLOCK_BIT  = 2;
  localparam int BUS_DATA_BIT   = 3;
  localparam int CLKOUT_PORT    = 2;
  localparam int CLKOUT_BIT     = 0;

  // Config register fields
  localparam int CFG_SCHMITT0   = 0;
  localparam int CFG_SCHMITT1   = 1;
  localparam int CFG_SCHMITT3   = 2;
  localparam int CFG_CLKOUT_EN  = 3;
  localparam int CFG_RC_SOURCE  = 4;

  // Read-modify-write command fields
  localparam int RMW_ARG_LSB    = 0;
  localparam int RMW_BIT_LSB    = 8;
  localparam int RMW_PORT_LSB   = 11;
  localparam int RMW_OP_LSB     = 13;
  localparam int RMW_CARRY_BIT  = 17;
  localparam int RMW_FLAG_BIT   = 8;

  localparam logic [3:0] OP_AND  = 4'h0;
  localparam logic [3:0] OP_OR   = 4'h1;
  localparam logic [3:0] OP_XOR  = 4'h2;
  localparam logic [3:0] OP_JBC  = 4'h3;
  localparam logic [3:0] OP_CPL  = 4'h4;
  localparam logic [3:0] OP_INC  = 4'h5;
  localparam logic [3:0] OP_DEC  = 4'h6;
  localparam logic [3:0] OP_DJNZ = 4'h7;
  localparam logic [3:0] OP_MOVC = 4'h8;
  localparam logic [3:0] OP_CLR  = 4'h9;
  localparam logic [3:0] OP_SET  = 4'ha;

  // Timing counts in peripheral clock cycles
  localparam int STRONG_PULLUP_CYCLES = 2;
  localparam int CLKOUT_DIVIDE        = 4;
  localparam int CLKOUT_HALF          = CLKOUT_DIVIDE / 2;

endpackage

// ---- verilog/pin_sync.sv ----
/*
  Three-stage pin synchroniser with agreement filter.
  Assumes asynchronous pin levels; the sampled level moves only when
  the second and third stages agree.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 24
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Pins and sampled result
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level
);

  initial begin
    if (WIDTH < 1) $error("pin_sync needs at least one bit");
  end

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] level;
  } sync_t;

  sync_t cur;
  sync_t next_cur;

  always_comb begin
    next_cur        = cur;
    next_cur.stage1 = async_in;
    next_cur.stage2 = cur.stage1;
    next_cur.stage3 = cur.stage2;
    // Glitch of one sample never reaches the level
    next_cur.level  = (cur.stage2 & cur.stage3) | (cur.level & (cur.stage2 ^ cur.stage3));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign level = cur.level;

endmodule // pin_sync

// ---- tb/gpio_port_properties.sv ----
/*
  Checker for gpio_port: pad control and APB timing relations.
  Sees only the top module ports; bound at the foot of this file.
*/
`timescale 1ns/1ps
module gpio_port_checker
  import gpio_pkg::*;
#(
  parameter int STRONG_CYCLES = 2
) (
  // Clock and reset
  input wire logic                 pclk,
  input wire logic                 presetn,
  // APB
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire logic                 pready,
  // Pads
  input wire logic [NUM_PINS-1:0]  pin_in,
  input wire logic [NUM_PINS-1:0]  pin_out,
  input wire logic [NUM_PINS-1:0]  pin_oe,
  input wire logic [NUM_PINS-1:0]  pull_down,
  input wire logic [NUM_PINS-1:0]  strong_pull_up,
  input wire logic [NUM_PINS-1:0]  weak_pull_up,
  input wire logic [NUM_PINS-1:0]  very_weak_pull_up,
  input wire logic [NUM_PORTS-1:0] schmitt_select
);
  int unsigned run;

  // Length of the current strong pulse on pin 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= 0;
    end else begin
      run <= strong_pull_up[0] ? run + 1 : 0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_bus_od;
    (strong_pull_up[11:10] | weak_pull_up[11:10] | very_weak_pull_up[11:10]) == 2'h0;
  endproperty
  a_bus_od: assert property (p_bus_od)
    else $error("bus pin pulled up");

  property p_no_fight;
    (pull_down & (strong_pull_up | very_weak_pull_up)) == '0;
  endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("pull-down and pull-up together");

  property p_oe;
    pin_oe == (pull_down | strong_pull_up) && pin_out == strong_pull_up;
  endproperty
  a_oe: assert property (p_oe)
    else $error("drive enable mismatch");

  property p_strong;
    $fell(strong_pull_up[0]) && very_weak_pull_up[0] |-> run == STRONG_CYCLES;
  endproperty
  a_strong: assert property (p_strong)
    else $error("strong pulse length wrong");

  property p_weak;
    !pin_in[0] [*6] |-> !weak_pull_up[0];
  endproperty
  a_weak: assert property (p_weak)
    else $error("weak pull-up on low pin");

  property p_clk;
    $rose(strong_pull_up[16]) ##1 strong_pull_up[16] ##1 pull_down[16]
      |-> ##1 pull_down[16] ##1 strong_pull_up[16];
  endproperty
  a_clk: assert property (p_clk)
    else $error("clock output period wrong");

  property p_cfg;
    psel && penable && pready && pwrite && paddr == REG_CONFIG
      |=> schmitt_select == $past(pwdata[2:0]);
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("input type select not updated");

  property p_rdy;
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_rdy: assert property (p_rdy)
    else $error("ready timing wrong");

  c_strong: cover property ($fell(strong_pull_up[0]) && very_weak_pull_up[0]);
  c_clk: cover property ($rose(strong_pull_up[16]));
  c_cfg: cover property (psel && penable && pready && paddr == REG_CONFIG);
endmodule // gpio_port_checker

bind gpio_port gpio_port_checker #(.STRONG_CYCLES(STRONG_CYCLES)) chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe(pin_oe), .pull_down(pull_down), .strong_pull_up(strong_pull_up),
  .weak_pull_up(weak_pull_up), .very_weak_pull_up(very_weak_pull_up),
  .schmitt_select(schmitt_select)
);

// ---- tb/pin_partner.sv ----
/*
  Circuitry on the port pins: resolves drivers and pulls into pin levels.
  Assumes the bench drives ext_en/ext_val to act as an outside driver.
*/
`timescale 1ns/1ps
module pin_partner
  import gpio_pkg::*;
(
  // Clock
  input wire logic                pclk,
  // Pad controls
  input wire logic [NUM_PINS-1:0] pull_down,
  input wire logic [NUM_PINS-1:0] strong_pull_up,
  input wire logic [NUM_PINS-1:0] weak_pull_up,
  input wire logic [NUM_PINS-1:0] very_weak_pull_up,
  // Outside driver
  input wire logic [NUM_PINS-1:0] ext_en,
  input wire logic [NUM_PINS-1:0] ext_val,
  // Resolved level
  output logic     [NUM_PINS-1:0] pin_level
);
  logic [NUM_PINS-1:0] float_pat = '0;

  // Undriven pins wander so a stale level never looks valid
  always @(posedge pclk) float_pat <= ~float_pat;

  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (ext_en[i]) pin_level[i] = ext_val[i];
      else if (pull_down[i]) pin_level[i] = 1'b0;
      else if (strong_pull_up[i] | weak_pull_up[i] | very_weak_pull_up[i]) pin_level[i] = 1'b1;
      else pin_level[i] = float_pat[i];
    end
  end
endmodule // pin_partner

// ---- tb/tb_top.sv ----
/*
  Self-checking bench for gpio_port over APB with a pin partner model.
  Assumes the checker is bound to the design from its own file.
*/
`timescale 1ns/1ps
module tb_top
  import gpio_pkg::*;
;
  `define CHK(a,b) begin n_checks++; if ((a) !== (b)) begin num_errors++; $display("FAIL t=%0t got %h exp %h", $time, (a), (b)); end end
  localparam int SC = 2;
  typedef struct packed {logic [3:0] op; logic [7:0] arg; logic [2:0] b; logic c; logic [8:0] x;} rmw_t;

  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]           paddr;
  logic [31:0]          pwdata, prdata;
  logic [NUM_PINS-1:0]  pin_in, pin_out, pin_oe, pull_down, strong_pull_up;
  logic [NUM_PINS-1:0]  weak_pull_up, very_weak_pull_up, ext_en, ext_val;
  logic [NUM_PORTS-1:0] schmitt_select;
  int                   num_errors, n_checks, tg;
  logic                 prev;
  rmw_t tbl [13] = '{
    '{OP_OR, 8'h00, 3'h0, 1'b0, 9'h0ff},
    '{OP_CLR, 8'h00, 3'h7, 1'b0, 9'h07f},
    '{OP_AND, 8'h5a, 3'h0, 1'b0, 9'h05a}, '{OP_AND, 8'h0f, 3'h0, 1'b0, 9'h00a},
    '{OP_OR, 8'h30, 3'h0, 1'b0, 9'h03a}, '{OP_XOR, 8'hff, 3'h0, 1'b0, 9'h0c5},
    '{OP_JBC, 8'h00, 3'h2, 1'b0, 9'h1c1}, '{OP_CPL, 8'h00, 3'h0, 1'b0, 9'h0c0},
    '{OP_INC, 8'h00, 3'h0, 1'b0, 9'h0c1}, '{OP_DEC, 8'h00, 3'h0, 1'b0, 9'h0c0},
    '{OP_DJNZ, 8'h00, 3'h0, 1'b0, 9'h1bf}, '{OP_MOVC, 8'h00, 3'h7, 1'b0, 9'h03f},
    '{OP_SET, 8'h00, 3'h6, 1'b0, 9'h07f}
  };

  gpio_port #(.STRONG_CYCLES(SC)) gpio_port_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pull_down(pull_down),
    .strong_pull_up(strong_pull_up), .weak_pull_up(weak_pull_up),
    .very_weak_pull_up(very_weak_pull_up), .schmitt_select(schmitt_select));

  pin_partner pin_partner_i (
    .pclk(pclk), .pull_down(pull_down), .strong_pull_up(strong_pull_up),
    .weak_pull_up(weak_pull_up), .very_weak_pull_up(very_weak_pull_up),
    .ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_in));

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    `CHK(pready, 1'b1)
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = '1,
                    input logic xe = 1'b0);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    `CHK(q & m, x & m)
    `CHK(e, xe)
  endtask

  task automatic stop_test();
    if (num_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    stop_test();
  end

  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; ext_en = 0; ext_val = 0;
    presetn = 0; num_errors = 0; n_checks = 0; tg = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    @(negedge pclk);
    `CHK(very_weak_pull_up, 24'h03f3ff)
    `CHK(pull_down, {~PORT3_RESET, 16'h0000})
    rd(REG_PORT0, 32'hff);
    for (int m = 0; m < 6; m++) rd(REG_MODE_LO0 + 8'(4 * m), 32'h0);
    rd(8'hfc, 32'h0, '1, 1'b1);
    wr(REG_PORT0, 32'h0);
    @(negedge pclk);
    `CHK({pull_down[7:0], very_weak_pull_up[7:0]}, 16'hff00)
    wr(REG_PORT0, 32'hff);
    repeat (SC) begin
      @(negedge pclk);
      `CHK(strong_pull_up[7:0], 8'hff)
    end
    @(negedge pclk);
    `CHK(strong_pull_up[7:0], 8'h00)
    // Outside driver pulls pin 0 low against the weak pull-up
    @(posedge pclk);
    ext_en <= 24'h1;
    repeat (8) @(posedge pclk);
    @(negedge pclk);
    `CHK(weak_pull_up[1:0], 2'h2)
    rd(REG_PORT0, 32'hfe);
    foreach (tbl[k]) begin
      wr(REG_RMW_CMD, 32'(tbl[k].arg) | 32'(tbl[k].b) << RMW_BIT_LSB | 32'(tbl[k].op) << RMW_OP_LSB
                      | 32'(tbl[k].c) << RMW_CARRY_BIT);
      rd(REG_RMW_RESULT, 32'(tbl[k].x), (tbl[k].op == OP_JBC || tbl[k].op == OP_DJNZ) ? 32'h1ff : 32'hff);
    end
    @(posedge pclk);
    ext_en <= '0;
    repeat (8) @(posedge pclk);
    @(negedge pclk);
    `CHK(pull_down[7:0], 8'h80)
    rd(REG_PORT0, 32'h7f);
    for (int m = 1; m < 4; m++) begin
      wr(REG_MODE_LO0, {24'h0, {8{m[0]}}});
      wr(REG_MODE_HI0, {24'h0, {8{m[1]}}});
      wr(REG_MODE_LO1, {24'h0, {8{m[0]}}});
      wr(REG_MODE_HI1, {24'h0, {8{m[1]}}});
      @(negedge pclk);
      `CHK(pull_down[7:0], m == 1 ? 8'h00 : 8'h80)
      `CHK(strong_pull_up[7:0], m == 2 ? 8'h7f : 8'h00)
      if (m != 2) `CHK(very_weak_pull_up[7:0] | weak_pull_up[7:0], 8'h00)
      `CHK({strong_pull_up[11:10], pull_down[11:10]}, 4'h0)
    end
    wr(REG_PORT1, 32'hf3);
    @(negedge pclk);
    `CHK(pull_down[11:10], 2'h3)
    `CHK({pin_oe[11:10], pin_out[11:10]}, 4'hc)
    wr(REG_CONFIG, 32'h5);
    @(negedge pclk);
    `CHK(schmitt_select, 3'h5)
    rd(REG_CONFIG, 32'h5);
    wr(REG_CONFIG, 32'h18);
    repeat (4) @(negedge pclk);
    prev = strong_pull_up[16];
    repeat (16) begin
      @(negedge pclk);
      if (strong_pull_up[16] !== prev) tg++;
      prev = strong_pull_up[16];
    end
    `CHK(32'(tg), 32'h8)
    stop_test();
  end
endmodule // tb_top
